// ### serdes_test_reset_control_tb_top.sv
/*
 * Self-checking bench for strc_test_reset_ctrl.
 * Assumes strc_host_model and the bound checker are compiled.
 */
`timescale 1ns/1ps
module serdes_test_reset_control_tb_top;
	localparam int POR = 20;
	logic            clk;
	logic            reset;
	logic            mdc;
	logic            mdio_w;
	logic            mdio_o;
	logic            mdio_oe;
	logic            host_o;
	logic            host_oe;
	logic            global_loopback_pin;
	logic            pattern_enable_pin;
	logic            tck;
	logic            tdi;
	logic            trst_n;
	logic            tdo;
	logic            echo;
	logic [7:0][9:0] tx_parallel_data;
	logic [7:0][9:0] rx_val;
	logic [7:0][9:0] bad;
	logic [7:0][9:0] rx_deser_data;
	logic [7:0][9:0] ser_word;
	logic [7:0][9:0] parallel_receive_bus;
	logic [7:0]      ser_out_oe;
	logic [7:0]      near_loop_sel;
	logic [7:0]      par_rx_oe;
	logic [7:0]      rx_clk_out_en;
	logic [7:0]      tx_channel_reset;
	logic [7:0]      rx_channel_reset;
	logic [3:0]      tx_bank_reset;
	logic [7:0]      seen_tx;
	logic [7:0]      seen_rx;
	logic [3:0]      seen_bank;
	logic            pattern_active;
	logic            por_active;
	logic [15:0]     rd;
	int              err_count;
	int              compares;

	assign mdio_w = mdio_oe ? mdio_o : host_oe ? host_o : 1'b1;
	// Receive words feed the lane checker, far loopback and parallel receive bus, never the host
	assign rx_deser_data = echo ? ser_word ^ bad : rx_val;

	strc_test_reset_ctrl #(.POR_CYCLES(POR)) u_strc_test_reset_ctrl
	(
		.clk, .reset, .mdc, .mdio_i(mdio_w), .mdio_o, .mdio_oe,
		.global_loopback_pin, .pattern_enable_pin, .tck, .tms(1'b0), .tdi,
		.trst_n, .tdo, .tx_parallel_data, .rx_deser_data, .ser_word,
		.ser_out_oe, .near_loop_sel, .parallel_receive_bus, .par_rx_oe,
		.rx_clk_out_en, .tx_channel_reset, .rx_channel_reset, .tx_bank_reset,
		.pattern_active, .por_active
	);

	strc_host_model u_strc_host_model
	(
		.clk, .mdio(mdio_w), .mdc, .host_o, .host_oe
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		seen_tx <= seen_tx | tx_channel_reset;
		seen_rx <= seen_rx | rx_channel_reset;
		seen_bank <= seen_bank | tx_bank_reset;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input string name, input logic [15:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		u_strc_host_model.frame(strc_pkg::OP_WR, a, d, rd);
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [15:0] e);
		u_strc_host_model.frame(strc_pkg::OP_RD, a, 16'h0000, rd);
		check($sformatf("reg %h", a), rd, e);
	endtask

	function automatic logic [9:0] nxt(input logic [6:0] s);
		logic [6:0] t;
		logic [9:0] w;
		t = s;
		for (int i = 9; i >= 0; i--)
		begin
			w[i] = t[6] ^ t[5];
			t = {t[5:0], w[i]};
		end
		return w;
	endfunction

	task automatic t_por;
		tick(2);
		check("por", {rx_clk_out_en, par_rx_oe}, 16'h0000);
		check("por on", {15'h0000, por_active}, 16'h0001);
		tick(POR);
		check("por end", {por_active, rx_clk_out_en}, 16'h00ff);
		rdchk(strc_pkg::REG_FTEST, 16'h000b);
		rdchk(strc_pkg::REG_PRES, 16'h0000);
		rdchk(strc_pkg::REG_LOOP, 16'h0000);
	endtask

	task automatic t_ro;
		logic [4:0] ro[4] = '{5'h1a, 5'h1b, 5'h1c, 5'h1f};
		foreach (ro[i])
		begin
			wr(ro[i], 16'hffff);
			rdchk(ro[i], 16'h0000);
		end
		rdchk(5'h05, 16'h0000);
		wr(strc_pkg::REG_FTEST, 16'hffff);
		rdchk(strc_pkg::REG_FTEST, 16'hff7f);
	endtask

	task automatic t_chrst;
		seen_tx = 8'h00;
		seen_rx = 8'h00;
		seen_bank = 4'h0;
		wr(strc_pkg::REG_CHRST, 16'h4006);
		tick(4);
		check("tx rst", seen_tx, 16'h0006);
		check("rx rst", seen_rx, 16'h0040);
		check("bank", seen_bank, 16'h0003);
		rdchk(strc_pkg::REG_CHRST, 16'h0000);
	endtask

	task automatic t_loop;
		wr(strc_pkg::REG_LOOP, 16'h0300);
		check("near", {near_loop_sel, ser_out_oe}, 16'h03fc);
		global_loopback_pin = 1'b1;
		tick(4);
		check("pin near", {near_loop_sel, ser_out_oe}, 16'hff00);
		global_loopback_pin = 1'b0;
		wr(strc_pkg::REG_LOOP, 16'h0001);
		wr(strc_pkg::REG_CHRST, 16'h0101);
		tx_parallel_data[1:0] = {10'h0ab, 10'h155};
		rx_val[0] = 10'h2aa;
		tick(2);
		check("far", ser_word[0], 16'h02aa);
		check("tx", ser_word[1], 16'h00ab);
		check("par oe", par_rx_oe, 16'h00fe);
		check("par rx", parallel_receive_bus[0], 16'h02aa);
		rdchk(strc_pkg::REG_LOOP, 16'h0001);
		wr(strc_pkg::REG_LOOP, 16'h0000);
	endtask

	task automatic t_prbs;
		logic [9:0] w;
		echo = 1'b1;
		wr(strc_pkg::REG_CTRL6, 16'h0300);
		rdchk(strc_pkg::REG_CTRL6, 16'h0300);
		for (int i = 0; i < 4; i++)
		begin
			w = ser_word[2];
			tx_parallel_data[2] = w;
			tick(1);
			check("prbs", ser_word[2], nxt(w[6:0]));
		end
		rdchk(strc_pkg::REG_PRES, 16'hff00);
		bad[3] = 10'h001;
		rdchk(strc_pkg::REG_PRES, 16'hf700);
		bad[3] = 10'h000;
		wr(strc_pkg::REG_CTRL6, 16'h0100);
		rdchk(strc_pkg::REG_PRES, 16'h0000);
		wr(strc_pkg::REG_CTRL6, 16'h0000);
		pattern_enable_pin = 1'b1;
		rdchk(strc_pkg::REG_PRES, 16'hff00);
		pattern_enable_pin = 1'b0;
		echo = 1'b0;
	endtask

	task automatic t_scan;
		trst_n = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			tdi = i < 3;
			tck = 1'b1;
			tick(4);
			tck = 1'b0;
			tick(4);
			if (i == 2 || i == 5)
				check("tdo", tdo, {15'h0, i == 2});
		end
	endtask

	task automatic results;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		reset = 1'b1;
		{global_loopback_pin, pattern_enable_pin, tck, tdi, trst_n} = 5'h00;
		{echo, tx_parallel_data, rx_val, bad} = '0;
		{err_count, compares} = '0;
		tick(5);
		reset = 1'b0;
		t_por;
		t_ro;
		t_chrst;
		t_loop;
		t_prbs;
		t_scan;
		results;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		err_count++;
		results;
	end
endmodule

// ### strc_checker.sv
/*
 * Port assertions for strc_test_reset_ctrl.
 * Assumes an 8 clk MDC period and mode pins held 4 clk or more.
 */
`timescale 1ns/1ps
module strc_checker
#(
	parameter int POR_CYCLES = 20
)
(
	input wire logic             clk,
	input wire logic             reset,
	input wire logic             global_loopback_pin,
	input wire logic             pattern_enable_pin,
	input wire logic [7:0][9:0]  rx_deser_data,
	input wire logic [7:0][9:0]  ser_word,
	input wire logic [7:0]       ser_out_oe,
	input wire logic [7:0]       near_loop_sel,
	input wire logic [7:0]       par_rx_oe,
	input wire logic [7:0]       rx_clk_out_en,
	input wire logic [7:0]       tx_channel_reset,
	input wire logic [7:0]       rx_channel_reset,
	input wire logic [3:0]       tx_bank_reset,
	input wire logic             pattern_active,
	input wire logic             por_active
);
	logic [31:0] por_cnt_r;
	logic [31:0] por_cnt_nxt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	// Counts cycles of power-on hold
	always_comb
	begin
		por_cnt_nxt = por_cnt_r + {31'h0, por_active};
	end

	always_ff @(posedge clk)
	begin
		por_cnt_r <= reset ? 32'h0 : por_cnt_nxt;
	end

	tx_pulse_a: assert property (
		$rose(|tx_channel_reset) |-> (|tx_channel_reset)[*8] ##1
		tx_channel_reset == 8'h00) else $error("tx reset pulse length");
	rx_pulse_a: assert property (
		$rose(|rx_channel_reset) |=> $stable(rx_channel_reset)[*7] ##1
		rx_channel_reset == 8'h00) else $error("rx reset pulse length");
	bank_or_a: assert property (
		tx_bank_reset == {|tx_channel_reset[7:6], |tx_channel_reset[5:4],
		|tx_channel_reset[3:2], |tx_channel_reset[1:0]})
		else $error("bank reset not pair OR");
	near_oe_a: assert property (
		ser_out_oe == ~near_loop_sel) else $error("serial out enable");
	pin_loop_a: assert property (
		global_loopback_pin[*4] |-> near_loop_sel == 8'hff)
		else $error("loop pin ignored");
	pin_pattern_a: assert property (
		pattern_enable_pin[*4] |-> pattern_active)
		else $error("pattern pin ignored");
	por_hold_a: assert property (
		por_active |-> rx_clk_out_en == 8'h00 && par_rx_oe == 8'h00)
		else $error("outputs live in power-on");
	por_len_a: assert property (
		$fell(por_active) |-> por_cnt_r >= POR_CYCLES
		&& por_cnt_r <= POR_CYCLES + 1) else $error("power-on length");
	far_echo_a: assert property (
		!par_rx_oe[0] && !por_active && !pattern_active |=>
		ser_word[0] == $past(rx_deser_data[0])) else $error("far loop echo");
endmodule

bind strc_test_reset_ctrl strc_checker #(.POR_CYCLES(POR_CYCLES)) u_strc_checker
(
	.clk, .reset, .global_loopback_pin, .pattern_enable_pin, .rx_deser_data,
	.ser_word, .ser_out_oe, .near_loop_sel, .par_rx_oe, .rx_clk_out_en,
	.tx_channel_reset, .rx_channel_reset, .tx_bank_reset, .pattern_active,
	.por_active
);

// ### strc_host_model.sv
/*
 * Management station: runs MDC only within frames, 8 clk per bit.
 * Assumes the bench resolves the pulled-up MDIO wire.
 */
`timescale 1ns/1ps
module strc_host_model
(
	input  wire logic clk,
	input  wire logic mdio,
	output logic      mdc,
	output logic      host_o,
	output logic      host_oe
);
	initial
	begin
		mdc = 1'b0;
		host_o = 1'b1;
		host_oe = 1'b0;
	end

	// One frame plus one idle bit that lets reset bits clear
	task automatic frame(input logic [1:0] op, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] bits;
		bits = {32'hffffffff, strc_pkg::ST_CODE, op, 5'h00, ra, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= -1; i--)
		begin
			@(posedge clk);
			#1;
			mdc = 1'b0;
			host_oe = i >= 0 && (op == strc_pkg::OP_WR || i > 17);
			host_o = i >= 0 ? bits[i] : 1'b1;
			repeat (4) @(posedge clk);
			#1;
			if (i >= 0 && i < 16)
				rd = {rd[14:0], mdio};
			mdc = 1'b1;
			repeat (3) @(posedge clk);
		end
		@(posedge clk);
		#1;
		mdc = 1'b0;
	endtask
endmodule

// ### strc_pkg.sv
/*
 * Shared constants, types and helpers for the serdes test and reset block.
 * Assumes a 200 MHz core clock and a Clause 22 management frame on MDC/MDIO.
 */
package strc_pkg;

	localparam int NUM_CH = 8;
	localparam int WORD_W = 10;
	localparam int NUM_PAIR = NUM_CH / 2;

	localparam logic [4:0] REG_LOOP  = 5'h16;
	localparam logic [4:0] REG_CTRL6 = 5'h18;
	localparam logic [4:0] REG_STAT0 = 5'h1a;
	localparam logic [4:0] REG_STAT1 = 5'h1b;
	localparam logic [4:0] REG_STAT2 = 5'h1c;
	localparam logic [4:0] REG_CHRST = 5'h1d;
	localparam logic [4:0] REG_FTEST = 5'h1e;
	localparam logic [4:0] REG_PRES  = 5'h1f;

	localparam int RX_RST_LSB    = 8;
	localparam int TX_RST_LSB    = 0;
	localparam int NEAR_LOOP_LSB = 8;
	localparam int FAR_LOOP_LSB  = 0;
	localparam int RX_PASS_LSB   = 8;
	localparam int TX_PASS_LSB   = 0;
	localparam int VERIFY_BIT    = 9;
	localparam int GEN_BIT       = 8;
	localparam int FTEST_RO_BIT  = 7;

	localparam logic [15:0] LOOP_RST  = 16'h0000;
	localparam logic [1:0]  CTRL6_RST = 2'h0;
	localparam logic [15:0] CHRST_RST = 16'h0000;
	localparam logic [15:0] FTEST_RST = 16'h000b;
	localparam logic [7:0]  PASS_RST  = 8'h00;
	localparam logic [15:0] STAT_VAL  = 16'h0000;

	localparam logic [5:0] PREAMBLE_LEN = 6'h20;
	localparam logic [5:0] HDR_LAST     = 6'h0d;
	localparam logic [5:0] TA_LAST      = 6'h01;
	localparam logic [5:0] DATA_LAST    = 6'h0f;
	localparam logic [1:0] ST_CODE      = 2'h1;
	localparam logic [1:0] OP_RD        = 2'h2;
	localparam logic [1:0] OP_WR        = 2'h1;

	localparam int POR_TIME_US = 1000;
	localparam int CLK_MHZ     = 200;
	localparam int POR_CYCLES  = POR_TIME_US * CLK_MHZ;

	localparam logic [6:0] PRBS_SEED = 7'h7f;

	typedef enum logic [3:0]
	{
		ST_PRE  = 4'b0001,
		ST_HDR  = 4'b0010,
		ST_TA   = 4'b0100,
		ST_DATA = 4'b1000
	} strc_mdio_e;

	typedef struct packed
	{
		logic near_loop;
		logic far_loop;
		logic gen_en;
		logic ver_en;
		logic tx_rst;
		logic rx_rst;
	} strc_chan_ctl_s;

	typedef struct packed
	{
		logic [1:0] st;
		logic [1:0] op;
		logic [4:0] phy;
		logic [4:0] regad;
	} strc_hdr_s;

	// Ten steps of x^7 + x^6 + 1, first bit in bit 9
	function automatic logic [9:0] strc_prbs_word(input logic [6:0] s);
		logic [6:0] t;
		logic [9:0] w;
		logic       nb;
		t = s;
		w = 10'h000;
		for (int i = 0; i < 10; i++)
		begin
			nb = t[6] ^ t[5];
			w[9 - i] = nb;
			t = {t[5:0], nb};
		end
		return w;
	endfunction

endpackage

// ### strc_prbs_lane.sv
/*
 * One channel lane: pattern generator, serializer input select, checker.
 * Assumes receive words arrive on clk, newest bit in bit 0.
 */
`timescale 1ns/1ps
module strc_prbs_lane
(
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire strc_pkg::strc_chan_ctl_s ctl,
	input  wire logic [9:0]             tx_parallel,
	input  wire logic [9:0]             rx_deser,
	output logic      [9:0]             ser_word,
	output logic                        pass
);

	logic [6:0] lfsr_r;
	logic [6:0] lfsr_nxt;
	logic [9:0] ser_r;
	logic [9:0] ser_nxt;
	logic [9:0] prev_rx_r;
	logic       pass_r;
	logic       pass_nxt;
	logic [9:0] gen_word;
	logic [9:0] expect_word;

	always_comb
	begin
		gen_word = strc_pkg::strc_prbs_word(lfsr_r);
		expect_word = strc_pkg::strc_prbs_word(prev_rx_r[6:0]);
		if (ctl.tx_rst || !ctl.gen_en)
			lfsr_nxt = strc_pkg::PRBS_SEED;
		else
			lfsr_nxt = gen_word[6:0];
		if (ctl.gen_en)
			ser_nxt = gen_word;
		else if (ctl.far_loop)
			ser_nxt = rx_deser;
		else
			ser_nxt = tx_parallel;
		pass_nxt = ctl.ver_en && !ctl.rx_rst && rx_deser != 10'h000
			&& rx_deser == expect_word;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			lfsr_r    <= strc_pkg::PRBS_SEED;
			ser_r     <= 10'h000;
			prev_rx_r <= 10'h000;
			pass_r    <= 1'b0;
		end
		else
		begin
			lfsr_r    <= lfsr_nxt;
			ser_r     <= ser_nxt;
			prev_rx_r <= rx_deser;
			pass_r    <= pass_nxt;
		end
	end

	assign ser_word = ser_r;
	assign pass     = pass_r;

endmodule

// ### strc_test_reset_ctrl.sv
/*
 * Test, loopback and reset control with a management frame slave.
 * Assumes MDC, MDIO and mode pins are asynchronous to clk and slow.
 */
//
// Behaviour
// - Writing one to upper reset byte resets that channel's receive path.
// - Writing one to lower reset byte resets that channel's transmit path.
// - Reset bits clear themselves on the next MDC cycle.
// - Transmit pairs share a bank; either channel's reset resets the bank.
// - Registers 0x1a to 0x1c always read zero.
// - Upper byte of result register shows per-channel receive pattern pass.
// - Lower byte of result register is factory pass info, reads zero.
// - Near-end loopback by global pin or per-channel upper loopback byte.
// - Near-end loopback floats serial output and ignores serial input.
// - Lower loopback byte routes received data back to the transmitter.
// - Far-end loopback ignores parallel input, floats parallel outputs.
// - Power-on reset floats receive data and holds receive clocks low.
// - Power-on reset lasts about one millisecond.
// - Self-test loads a seven-stage pattern into the 10-bit serializer word.
// - Self-test enabled by pattern pin or register enable bit.
// - Transmit parallel data is ignored while pattern test runs.
// - Factory register resets to 0x000b, bit 7 read-only.
// - Five-terminal boundary-scan port is provided.
// - Control six bit 9 enables verification, bit 8 generation.
// - Register near-end loopback bits are ORed with the global loopback pin.
`timescale 1ns/1ps
module strc_test_reset_ctrl
#(
	parameter int         POR_CYCLES = strc_pkg::POR_CYCLES,
	parameter logic [4:0] PHY_ADDR   = 5'h00
)
(
	input  wire logic                                clk,
	input  wire logic                                reset,
	input  wire logic                                mdc,
	input  wire logic                                mdio_i,
	output logic                                     mdio_o,
	output logic                                     mdio_oe,
	input  wire logic                                global_loopback_pin,
	input  wire logic                                pattern_enable_pin,
	input  wire logic                                tck,
	input  wire logic                                tms,
	input  wire logic                                tdi,
	input  wire logic                                trst_n,
	output logic                                     tdo,
	input  wire logic [strc_pkg::NUM_CH-1:0][9:0]    tx_parallel_data,
	input  wire logic [strc_pkg::NUM_CH-1:0][9:0]    rx_deser_data,
	output logic      [strc_pkg::NUM_CH-1:0][9:0]    ser_word,
	output logic      [strc_pkg::NUM_CH-1:0]         ser_out_oe,
	output logic      [strc_pkg::NUM_CH-1:0]         near_loop_sel,
	output logic      [strc_pkg::NUM_CH-1:0][9:0]    parallel_receive_bus,
	output logic      [strc_pkg::NUM_CH-1:0]         par_rx_oe,
	output logic      [strc_pkg::NUM_CH-1:0]         rx_clk_out_en,
	output logic      [strc_pkg::NUM_CH-1:0]         tx_channel_reset,
	output logic      [strc_pkg::NUM_CH-1:0]         rx_channel_reset,
	output logic      [strc_pkg::NUM_PAIR-1:0]       tx_bank_reset,
	output logic                                     pattern_active,
	output logic                                     por_active
);

	localparam int NCH = strc_pkg::NUM_CH;

	// Input synchronisers: mdc, mdio, loop pin, pattern pin, tck, tdi, trst_n
	logic [6:0] sync1_r;
	logic [6:0] sync2_r;
	logic       mdc_d_r;
	logic       tck_d_r;
	logic       mdc_rise;
	logic       tck_rise;
	logic       mdio_s;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sync1_r <= 7'h00;
			sync2_r <= 7'h00;
			mdc_d_r <= 1'b0;
			tck_d_r <= 1'b0;
		end
		else
		begin
			sync1_r <= {trst_n, tdi, tck, pattern_enable_pin,
				global_loopback_pin, mdio_i, mdc};
			sync2_r <= sync1_r;
			mdc_d_r <= sync2_r[0];
			tck_d_r <= sync2_r[4];
		end
	end

	assign mdc_rise = sync2_r[0] && !mdc_d_r;
	assign tck_rise = sync2_r[4] && !tck_d_r;
	assign mdio_s   = sync2_r[1];

	// Boundary-scan port: bypass path only
	logic bypass_r;
	logic bypass_nxt;
	logic tdo_r;
	logic tdo_nxt;

	always_comb
	begin
		bypass_nxt = bypass_r;
		tdo_nxt = tdo_r;
		if (!sync2_r[6])
		begin
			bypass_nxt = 1'b0;
			tdo_nxt = 1'b0;
		end
		else if (tck_rise)
		begin
			bypass_nxt = sync2_r[5];
			tdo_nxt = bypass_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bypass_r <= 1'b0;
			tdo_r    <= 1'b0;
		end
		else
		begin
			bypass_r <= bypass_nxt;
			tdo_r    <= tdo_nxt;
		end
	end

	assign tdo = tdo_r;

	// Power-on reset counter
	logic [31:0] por_cnt_r;
	logic [31:0] por_cnt_nxt;

	always_comb
	begin
		por_cnt_nxt = por_cnt_r;
		if (por_cnt_r != 32'h0)
			por_cnt_nxt = por_cnt_r - 32'h1;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			por_cnt_r <= 32'(POR_CYCLES);
		else
			por_cnt_r <= por_cnt_nxt;
	end

	assign por_active = por_cnt_r != 32'h0;

	// Management registers and frame engine
	strc_pkg::strc_mdio_e state_r;
	strc_pkg::strc_mdio_e state_nxt;
	logic [5:0]  cnt_r;
	logic [5:0]  cnt_nxt;
	logic [15:0] sh_r;
	logic [15:0] sh_nxt;
	logic        rd_r;
	logic        rd_nxt;
	logic [4:0]  reg_r;
	logic [4:0]  reg_nxt;
	logic        o_r;
	logic        o_nxt;
	logic        oe_r;
	logic        oe_nxt;
	logic [15:0] loop_r;
	logic [15:0] loop_nxt;
	logic [1:0]  ctrl6_r;
	logic [1:0]  ctrl6_nxt;
	logic [15:0] chrst_r;
	logic [15:0] chrst_nxt;
	logic [15:0] ftest_r;
	logic [15:0] ftest_nxt;
	logic [NCH-1:0] pass_vec;
	logic [13:0] hdr_bits;
	strc_pkg::strc_hdr_s hdr;
	logic [15:0] wr_word;

	function automatic logic [15:0] read_value(input logic [4:0] a,
		input logic [15:0] lp, input logic [1:0] c6,
		input logic [15:0] cr, input logic [15:0] ft,
		input logic [7:0] pv);
		logic [15:0] v;
		v = strc_pkg::STAT_VAL;
		unique case (a)
			strc_pkg::REG_LOOP:  v = lp;
			strc_pkg::REG_CTRL6: v = {6'h00, c6, 8'h00};
			strc_pkg::REG_CHRST: v = cr;
			strc_pkg::REG_FTEST: v = ft;
			strc_pkg::REG_PRES:  v = {pv, strc_pkg::PASS_RST};
			default:             v = strc_pkg::STAT_VAL;
		endcase
		return v;
	endfunction

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		rd_nxt = rd_r;
		reg_nxt = reg_r;
		o_nxt = o_r;
		oe_nxt = oe_r;
		loop_nxt = loop_r;
		ctrl6_nxt = ctrl6_r;
		chrst_nxt = chrst_r;
		ftest_nxt = ftest_r;
		hdr_bits = {sh_r[12:0], mdio_s};
		hdr = hdr_bits;
		wr_word = {sh_r[14:0], mdio_s};
		if (mdc_rise)
		begin
			chrst_nxt = strc_pkg::CHRST_RST;
			unique case (state_r)
				strc_pkg::ST_PRE:
				begin
					if (mdio_s && cnt_r != strc_pkg::PREAMBLE_LEN)
						cnt_nxt = cnt_r + 6'h1;
					else if (!mdio_s && cnt_r == strc_pkg::PREAMBLE_LEN)
					begin
						state_nxt = strc_pkg::ST_HDR;
						cnt_nxt = 6'h1;
						sh_nxt = 16'h0000;
					end
					else if (!mdio_s)
						cnt_nxt = 6'h0;
				end
				strc_pkg::ST_HDR:
				begin
					sh_nxt = {sh_r[14:0], mdio_s};
					cnt_nxt = cnt_r + 6'h1;
					if (cnt_r == strc_pkg::HDR_LAST)
					begin
						cnt_nxt = 6'h0;
						reg_nxt = hdr.regad;
						rd_nxt = hdr.op == strc_pkg::OP_RD;
						if (hdr.st == strc_pkg::ST_CODE && hdr.phy == PHY_ADDR
							&& (hdr.op == strc_pkg::OP_RD
							|| hdr.op == strc_pkg::OP_WR))
							state_nxt = strc_pkg::ST_TA;
						else
							state_nxt = strc_pkg::ST_PRE;
					end
				end
				strc_pkg::ST_TA:
				begin
					cnt_nxt = cnt_r + 6'h1;
					if (cnt_r != strc_pkg::TA_LAST)
					begin
						oe_nxt = rd_r;
						o_nxt = 1'b0;
					end
					else
					begin
						state_nxt = strc_pkg::ST_DATA;
						cnt_nxt = 6'h0;
						sh_nxt = read_value(reg_r, loop_r, ctrl6_r, chrst_r,
							ftest_r, pass_vec);
						o_nxt = sh_nxt[15];
						sh_nxt = {sh_nxt[14:0], 1'b0};
					end
				end
				strc_pkg::ST_DATA:
				begin
					cnt_nxt = cnt_r + 6'h1;
					if (rd_r)
					begin
						o_nxt = sh_r[15];
						sh_nxt = {sh_r[14:0], 1'b0};
					end
					else
						sh_nxt = wr_word;
					if (cnt_r == strc_pkg::DATA_LAST)
					begin
						state_nxt = strc_pkg::ST_PRE;
						cnt_nxt = 6'h0;
						oe_nxt = 1'b0;
						o_nxt = 1'b0;
						if (!rd_r)
						begin
							unique case (reg_r)
								strc_pkg::REG_LOOP: loop_nxt = wr_word;
								strc_pkg::REG_CTRL6:
									ctrl6_nxt = wr_word[9:8];
								strc_pkg::REG_CHRST:
									chrst_nxt = wr_word;
								strc_pkg::REG_FTEST:
								begin
									ftest_nxt = wr_word;
									ftest_nxt[strc_pkg::FTEST_RO_BIT] =
										ftest_r[strc_pkg::FTEST_RO_BIT];
								end
								default: loop_nxt = loop_r;
							endcase
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r <= strc_pkg::ST_PRE;
			cnt_r   <= 6'h0;
			sh_r    <= 16'h0000;
			rd_r    <= 1'b0;
			reg_r   <= 5'h00;
			o_r     <= 1'b0;
			oe_r    <= 1'b0;
			loop_r  <= strc_pkg::LOOP_RST;
			ctrl6_r <= strc_pkg::CTRL6_RST;
			chrst_r <= strc_pkg::CHRST_RST;
			ftest_r <= strc_pkg::FTEST_RST;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			sh_r    <= sh_nxt;
			rd_r    <= rd_nxt;
			reg_r   <= reg_nxt;
			o_r     <= o_nxt;
			oe_r    <= oe_nxt;
			loop_r  <= loop_nxt;
			ctrl6_r <= ctrl6_nxt;
			chrst_r <= chrst_nxt;
			ftest_r <= ftest_nxt;
		end
	end

	assign mdio_o  = o_r;
	assign mdio_oe = oe_r;

	assign rx_channel_reset = chrst_r[strc_pkg::RX_RST_LSB +: NCH];
	assign tx_channel_reset = chrst_r[strc_pkg::TX_RST_LSB +: NCH];
	assign pattern_active = sync2_r[3] || ctrl6_r[0];

	// Channel lanes and output controls
	logic [NCH-1:0][9:0] par_rx_r;

	always_ff @(posedge clk)
	begin
		if (reset)
			par_rx_r <= '0;
		else
			par_rx_r <= rx_deser_data;
	end

	assign parallel_receive_bus = par_rx_r;

	for (genvar p = 0; p < strc_pkg::NUM_PAIR; p++)
	begin : g_pair
		assign tx_bank_reset[p] = tx_channel_reset[2 * p]
			|| tx_channel_reset[2 * p + 1];
	end

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		strc_pkg::strc_chan_ctl_s ctl;
		assign ctl.near_loop = sync2_r[2]
			|| loop_r[strc_pkg::NEAR_LOOP_LSB + c];
		assign ctl.far_loop = loop_r[strc_pkg::FAR_LOOP_LSB + c];
		assign ctl.gen_en = pattern_active;
		assign ctl.ver_en = ctrl6_r[1] || sync2_r[3];
		assign ctl.tx_rst = tx_channel_reset[c];
		assign ctl.rx_rst = rx_channel_reset[c];
		assign near_loop_sel[c] = ctl.near_loop;
		assign ser_out_oe[c] = !ctl.near_loop;
		assign par_rx_oe[c] = !por_active && !ctl.far_loop;
		assign rx_clk_out_en[c] = !por_active;

		strc_prbs_lane u_lane
		(
			.clk         (clk),
			.reset       (reset),
			.ctl         (ctl),
			.tx_parallel (tx_parallel_data[c]),
			.rx_deser    (rx_deser_data[c]),
			.ser_word    (ser_word[c]),
			.pass        (pass_vec[c])
		);
	end

endmodule
